// ### common/pss_regs.vh
// register map, field positions, reset values and timing counts of the power state supervisor
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// byte addresses of the register words
`define PSS_CTRL_ADDR 4'h0
`define PSS_STAT_ADDR 4'h4
`define PSS_ENAB_ADDR 4'h8
`define PSS_CONF_ADDR 4'hC

// control word fields
`define PSS_CTRL_SLEEP 0

// status word fields
`define PSS_STAT_CFG_LOSS 0
`define PSS_STAT_OTP 1
`define PSS_STAT_DRV_FAULT 2
`define PSS_STAT_THERM_WARN 3
`define PSS_STAT_MSG_PEND 4
`define PSS_STAT_TX_BUSY 5

// enables word fields
`define PSS_EN_LDO5 0
`define PSS_EN_BUCK 1
`define PSS_EN_WAKE 2
`define PSS_EN_LDO12 3
`define PSS_EN_DRV 4
`define PSS_EN_COMM 5
`define PSS_EN_SUPV 6
`define PSS_EN_PUMP 7

// reset values
`define PSS_CTRL_RESET 32'h00000000
`define PSS_CONF_RESET 32'h00000000
`define PSS_CFG_LOSS_RESET 1'h1

// status message header nibble (arbitrary value)
`define PSS_MSG_HEADER 4'hA

// axi responses
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2

// host link timing
`define PSS_CLK_HZ 100000000
`define PSS_LINK_BAUD 9600
`define PSS_BIT_CYCLES (`PSS_CLK_HZ / `PSS_LINK_BAUD)
`define PSS_DATA_BITS 8

`endif

// ### logic/pss_link_tx.v
// serial transmitter for the open-drain host status link: start, 8 data lsb first, stop
`timescale 1ns/100ps
`include "pss_regs.vh"

module pss_link_tx #(
    parameter BIT_CYCLES = `PSS_BIT_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire start,
    input wire [7:0] data,
    output reg busy,
    output reg drive_low
);

    ////////////////////////////////////////////////////////////////////////////
    // frame state
    reg [13:0] bit_timer;  // cycles left in the current bit
    reg [3:0] bit_index;   // 0 start, 1..8 data, 9 stop
    reg [9:0] frame;       // stop, data, start; shifted out lsb first

    localparam [13:0] BIT_LAST = BIT_CYCLES[13:0] - 14'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // shift out one frame per start pulse; starts while busy are ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            drive_low <= 1'b0;
            bit_timer <= 14'h0000;
            bit_index <= 4'h0;
            frame <= 10'h3FF;
        end else if (!busy) begin
            drive_low <= 1'b0;
            if (start) begin
                // start bit pulls the line low; idle level comes from the pull-up
                busy <= 1'b1;
                frame <= {1'b1, data, 1'b0};
                drive_low <= 1'b1;
                bit_timer <= BIT_LAST;
                bit_index <= 4'h0;
            end
        end else if (bit_timer != 14'h0000) begin
            bit_timer <= bit_timer - 14'h0001;
        end else if (bit_index == 4'h9) begin
            // stop bit done; line released
            busy <= 1'b0;
            drive_low <= 1'b0;
        end else begin
            // next bit: open drain only ever pulls low for a zero
            bit_index <= bit_index + 4'h1;
            drive_low <= ~frame[1];
            frame <= {1'b1, frame[9:1]};
            bit_timer <= BIT_LAST;
        end
    end

endmodule

// ### logic/pss_supervisor.v
// power state supervisor: function enables, fault latches, status messages, axi4-lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pss_regs.vh"

module pss_supervisor #(
    parameter BIT_CYCLES = `PSS_BIT_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // chip enable pin and analog comparator levels
    input wire chip_enable,
    input wire vdd_below_3v8,
    input wire vdd_below_4v0,
    input wire vdd_below_5v5,
    input wire vdd_above_20v,
    input wire vdd_above_32v,
    input wire vdd_below_pump_start,
    input wire temp_above_shutdown,
    input wire temp_above_hysteresis,
    input wire temp_above_warning,
    // function enables
    output reg ldo5_en,
    output reg buck_en,
    output reg wake_inputs_en,
    output reg ldo12_en,
    output reg motor_drivers_en,
    output reg host_comm_en,
    output reg supervisors_en,
    output reg charge_pump_en,
    // open-drain host_comm_pin
    output reg host_comm_pin_o,
    output reg host_comm_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    reg sleep_bit;                // software sleep request
    reg [31:0] config_word;       // configuration the host rewrites after a loss
    reg config_loss_warning;      // sticky, write one to clear
    reg otp_latched;              // overtemperature shutdown held
    reg ce_low_seen;              // chip enable went low while latched
    reg drv_fault_prev;           // edge detect of driver supply fault
    reg warn_prev;                // edge detect of thermal warning
    reg msg_pend;                 // a status message waits for the transmitter
    reg aw_held;                  // write address taken, waiting for data
    reg w_held;                   // write data taken, waiting for address
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire tx_busy;
    wire tx_drive_low;
    wire tx_start;

    // combinational enables
    reg next_ldo5_en;
    reg next_buck_en;
    reg next_wake_en;
    reg next_ldo12_en;
    reg next_drv_en;
    reg next_comm_en;
    reg next_supv_en;
    reg next_pump_en;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // apply byte enables to a register word
    function [31:0] pss_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            pss_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    pss_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // address decode, used by both write and read paths
    function pss_mapped;
        input [3:0] addr;
        begin
            pss_mapped = (addr == `PSS_CTRL_ADDR) || (addr == `PSS_STAT_ADDR) ||
                         (addr == `PSS_ENAB_ADDR) || (addr == `PSS_CONF_ADDR);
        end
    endfunction

    wire drv_fault = vdd_below_5v5 | vdd_above_20v;
    wire all_off = vdd_above_32v | otp_latched;
    wire sleep_mode = ~chip_enable & sleep_bit;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire stat_clear = do_write && (aw_addr == `PSS_STAT_ADDR) && w_strb[0] &&
                      w_data[`PSS_STAT_CFG_LOSS];
    wire [31:0] enab_word = {24'h000000, charge_pump_en, supervisors_en, host_comm_en,
                             motor_drivers_en, ldo12_en, wake_inputs_en, buck_en, ldo5_en};
    wire [31:0] stat_word = {26'h0, tx_busy, msg_pend, temp_above_warning, drv_fault,
                             otp_latched, config_loss_warning};
    wire [7:0] msg_byte = {`PSS_MSG_HEADER, temp_above_warning, vdd_above_20v,
                           vdd_below_5v5, config_loss_warning};

    ////////////////////////////////////////////////////////////////////////////
    // function enables from chip enable, sleep bit and faults
    always @* begin
        // extreme overvoltage or thermal shutdown kills everything
        next_wake_en = ~all_off;
        // sleep leaves only the wake-capable inputs; standby keeps the rails below except ldo12, drivers and pump, which need chip enable
        next_ldo5_en = ~all_off & ~sleep_mode;
        next_comm_en = ~all_off & ~sleep_mode;
        next_supv_en = ~all_off & ~sleep_mode;
        next_buck_en = ~all_off & ~sleep_mode & ~vdd_below_4v0;
        next_ldo12_en = ~all_off & chip_enable;
        // drivers only: bias, comm and control logic above ignore drv_fault
        next_drv_en = ~all_off & chip_enable & ~drv_fault;
        // pump boosts the 12V regulator input at low supply
        next_pump_en = ~all_off & chip_enable & vdd_below_pump_start;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ldo5_en <= 1'b0;
            buck_en <= 1'b0;
            wake_inputs_en <= 1'b0;
            ldo12_en <= 1'b0;
            motor_drivers_en <= 1'b0;
            host_comm_en <= 1'b0;
            supervisors_en <= 1'b0;
            charge_pump_en <= 1'b0;
        end else begin
            ldo5_en <= next_ldo5_en;
            buck_en <= next_buck_en;
            wake_inputs_en <= next_wake_en;
            ldo12_en <= next_ldo12_en;
            motor_drivers_en <= next_drv_en;
            host_comm_en <= next_comm_en;
            supervisors_en <= next_supv_en;
            charge_pump_en <= next_pump_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overtemperature latch and its release
    always @(posedge aclk) begin
        if (!aresetn) begin
            otp_latched <= 1'b0;
            ce_low_seen <= 1'b0;
        end else if (temp_above_shutdown) begin
            // a fresh trip always wins and restarts the release sequence
            otp_latched <= 1'b1;
            ce_low_seen <= 1'b0;
        end else if (otp_latched) begin
            if (!chip_enable) begin
                ce_low_seen <= 1'b1;
            end else if (ce_low_seen && !temp_above_hysteresis) begin
                // low then high on chip enable, and cooled past hysteresis
                otp_latched <= 1'b0;
                ce_low_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration loss flag: set at reset and on brown-out, set beats clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            config_loss_warning <= `PSS_CFG_LOSS_RESET;
        end else if (vdd_below_3v8) begin
            config_loss_warning <= 1'b1;
        end else if (stat_clear) begin
            config_loss_warning <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status messages on driver supply faults and thermal warnings
    // one pending flag: events during a frame merge into the next message,
    // which carries the live flags, so nothing reported is stale
    assign tx_start = msg_pend & ~tx_busy & host_comm_en;

    always @(posedge aclk) begin
        if (!aresetn) begin
            drv_fault_prev <= 1'b0;
            warn_prev <= 1'b0;
            msg_pend <= 1'b0;
        end else begin
            drv_fault_prev <= drv_fault;
            warn_prev <= temp_above_warning;
            if ((drv_fault & ~drv_fault_prev) | (temp_above_warning & ~warn_prev)) begin
                msg_pend <= 1'b1;
            end else if (tx_start) begin
                msg_pend <= 1'b0;
            end
        end
    end

    pss_link_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_link_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tx_start),
        .data(msg_byte),
        .busy(tx_busy),
        .drive_low(tx_drive_low)
    );

    // open drain: only ever pulls low, idle high from the external pull-up
    always @(posedge aclk) begin
        if (!aresetn) begin
            host_comm_pin_o <= 1'b0;
            host_comm_pin_oe <= 1'b0;
        end else begin
            host_comm_pin_o <= 1'b0;
            host_comm_pin_oe <= tx_drive_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSS_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            sleep_bit <= 1'b0;
            config_word <= `PSS_CONF_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                // perform the store; status bit clears are handled with the flag
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= pss_mapped(aw_addr) ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
                if (aw_addr == `PSS_CTRL_ADDR && w_strb[0]) begin
                    sleep_bit <= w_data[`PSS_CTRL_SLEEP];
                end
                if (aw_addr == `PSS_CONF_ADDR) begin
                    config_word <= pss_merge(config_word, w_data, w_strb);
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                // reopen both channels only once the response is gone
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel: data one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PSS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pss_mapped(s_axi_araddr) ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
            case (s_axi_araddr)
                `PSS_CTRL_ADDR: begin
                    s_axi_rdata <= {31'h0, sleep_bit};
                end
                `PSS_STAT_ADDR: begin
                    s_axi_rdata <= stat_word;
                end
                `PSS_ENAB_ADDR: begin
                    s_axi_rdata <= enab_word;
                end
                `PSS_CONF_ADDR: begin
                    s_axi_rdata <= config_word;
                end
                default: begin
                    // unmapped reads return zero with an error response
                    s_axi_rdata <= 32'h00000000;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ### verification/pss_host_model.sv
// host side receiver of the open-drain status link
`timescale 1ns/100ps
module pss_host_model #(
    parameter BIT_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic line,
    output logic [7:0] rx_byte,
    output logic [31:0] rx_count,
    output logic frame_err
);
    logic [7:0] sh; // shift register of the frame in flight
    // sample mid-bit: start low, 8 data lsb first, stop high
    initial begin
        rx_byte = 8'h00;
        rx_count = 32'h0;
        frame_err = 1'b0;
        forever begin
            @(negedge line);
            repeat (BIT_CYCLES / 2) @(posedge aclk);
            if (line !== 1'b0) frame_err = 1'b1;
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge aclk);
                sh[i] = line;
            end
            repeat (BIT_CYCLES) @(posedge aclk);
            if (line !== 1'b1) frame_err = 1'b1;
            rx_byte = sh;
            rx_count = rx_count + 1;
        end
    end
endmodule

// ### verification/pss_supervisor_monitor.sv
// checker for the power state supervisor enables and host link
`timescale 1ns/100ps
module pss_supervisor_monitor #(
    parameter BIT_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_enable,
    input wire logic vdd_below_4v0,
    input wire logic vdd_below_5v5,
    input wire logic vdd_above_20v,
    input wire logic vdd_above_32v,
    input wire logic vdd_below_pump_start,
    input wire logic temp_above_shutdown,
    input wire logic ldo5_en,
    input wire logic buck_en,
    input wire logic wake_inputs_en,
    input wire logic ldo12_en,
    input wire logic motor_drivers_en,
    input wire logic host_comm_en,
    input wire logic supervisors_en,
    input wire logic charge_pump_en,
    input wire logic host_comm_pin_o,
    input wire logic host_comm_pin_oe
);
    default clocking pss_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    logic oe_q; // link drive level one cycle back
    int unsigned run; // cycles spent at the present line level
    // run length of the driven-low periods, so bit widths can be judged
    always @(posedge aclk) begin
        if (!aresetn) begin
            oe_q <= 1'b0;
            run <= 0;
        end else begin
            oe_q <= host_comm_pin_oe;
            run <= (host_comm_pin_oe != oe_q) ? 1 : run + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence all_off_s;
        !ldo5_en && !buck_en && !wake_inputs_en && !ldo12_en && !motor_drivers_en
            && !host_comm_en && !supervisors_en && !charge_pump_en;
    endsequence
    // the otp latch is clear when the 12V rail was on and the die was not hot just before
    sequence keep_s;
        (vdd_below_5v5 || vdd_above_20v) && chip_enable && ldo12_en && !vdd_above_32v
            && !temp_above_shutdown && !$past(temp_above_shutdown);
    endsequence
    AST_OV32: assert property (vdd_above_32v |=> all_off_s)
        else $error("supply above top limit left a function enabled");
    AST_DRV_FAULT: assert property ((vdd_below_5v5 || vdd_above_20v) |=> !motor_drivers_en)
        else $error("motor drivers on during driver supply fault");
    AST_KEEP: assert property (keep_s |=> host_comm_en && ldo5_en && supervisors_en && ldo12_en)
        else $error("bias or comm dropped during driver supply fault");
    AST_BUCK_UV: assert property (vdd_below_4v0 |=> !buck_en)
        else $error("buck on with supply below its lockout");
    AST_OTP: assert property (temp_above_shutdown |-> ##2 all_off_s)
        else $error("function left on after overtemperature");
    AST_CE_LOW: assert property (!chip_enable |=> !ldo12_en && !motor_drivers_en && !charge_pump_en)
        else $error("chip enable low left 12V rail or drivers on");
    AST_PUMP: assert property ((chip_enable && wake_inputs_en && !vdd_above_32v
        && !temp_above_shutdown && !$past(temp_above_shutdown))
        |=> charge_pump_en == $past(vdd_below_pump_start))
        else $error("charge pump does not follow its start comparator");
    AST_PIN_O: assert property (host_comm_pin_oe |-> !host_comm_pin_o)
        else $error("status pin driven high");
    AST_LINK_BITS: assert property ((oe_q && !host_comm_pin_oe)
        |-> (run % BIT_CYCLES == 0) && (run <= 9 * BIT_CYCLES))
        else $error("low period on status line is not whole bits");
endmodule
bind pss_supervisor pss_supervisor_monitor #(.BIT_CYCLES(BIT_CYCLES)) pss_supervisor_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .chip_enable(chip_enable), .vdd_below_4v0(vdd_below_4v0),
    .vdd_below_5v5(vdd_below_5v5), .vdd_above_20v(vdd_above_20v), .vdd_above_32v(vdd_above_32v),
    .vdd_below_pump_start(vdd_below_pump_start), .temp_above_shutdown(temp_above_shutdown),
    .ldo5_en(ldo5_en), .buck_en(buck_en), .wake_inputs_en(wake_inputs_en), .ldo12_en(ldo12_en),
    .motor_drivers_en(motor_drivers_en), .host_comm_en(host_comm_en),
    .supervisors_en(supervisors_en), .charge_pump_en(charge_pump_en),
    .host_comm_pin_o(host_comm_pin_o), .host_comm_pin_oe(host_comm_pin_oe));

// ### verification/test_power_state_supervisor.sv
// self-checking bench for the power state supervisor
`timescale 1ns/100ps
`include "pss_regs.vh"
module test_power_state_supervisor;
    localparam int BITC = 8; // short bit time keeps frames quick
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rd, c0, conf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic ce = 1'b0, c, slp;
    logic [8:0] cmp = 9'h000, v; // comparator levels
    logic [1:0] rs;
    logic [10:0] corner [4] = '{11'h200, 11'h000, 11'h410, 11'h426}; // sleep, standby, 32V, low
    int ev [3] = '{2, 3, 8}; // comparators that raise a message
    int n_fail = 0, samples_checked = 0, cycles = 0;
    wire awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, line, ferr;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, rx_count;
    wire [7:0] en, rx_byte;
    ////////////////////////////////////////////////////////////////////////////////
    pss_supervisor #(.BIT_CYCLES(BITC)) pss_supervisor_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chip_enable(ce), .vdd_below_3v8(cmp[0]), .vdd_below_4v0(cmp[1]),
        .vdd_below_5v5(cmp[2]), .vdd_above_20v(cmp[3]), .vdd_above_32v(cmp[4]),
        .vdd_below_pump_start(cmp[5]), .temp_above_shutdown(cmp[6]),
        .temp_above_hysteresis(cmp[7]), .temp_above_warning(cmp[8]),
        .ldo5_en(en[0]), .buck_en(en[1]), .wake_inputs_en(en[2]), .ldo12_en(en[3]),
        .motor_drivers_en(en[4]), .host_comm_en(en[5]), .supervisors_en(en[6]),
        .charge_pump_en(en[7]), .host_comm_pin_o(pin_o), .host_comm_pin_oe(pin_oe));
    assign line = pin_oe ? pin_o : 1'b1; // external pull-up holds a released line high
    pss_host_model #(.BIT_CYCLES(BITC)) pss_host_model_i (
        .aclk(aclk), .line(line), .rx_byte(rx_byte), .rx_count(rx_count), .frame_err(ferr));
    ////////////////////////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    // hang guard, far above the expected run length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: run timed out", $time);
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // axi4-lite write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // expected enables {pump, supv, comm, drv, ldo12, wake, buck, ldo5} with no otp latched
    function automatic logic [7:0] exp_en(input logic ce_l, input logic s, input logic [8:0] l);
        logic ao, base, l12;
        ao = l[4];
        base = !ao && !(!ce_l && s);
        l12 = !ao && ce_l;
        return {l12 && l[5], base, base, l12 && !(l[2] || l[3]), l12, !ao, base && !l[1], base};
    endfunction
    // only the bench timeout ends a wait for a frame that never comes
    task automatic wait_rx(input logic [31:0] c_l);
        while (rx_count == c_l) @(posedge aclk);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(51131));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(`PSS_STAT_ADDR);
        chk(rd & 32'h1, 32'h1);
        wr(`PSS_STAT_ADDR, 32'h1);
        rd_reg(`PSS_STAT_ADDR);
        chk(rd & 32'h1, 32'h0);
        @(posedge aclk);
        cmp <= 9'h001;
        @(posedge aclk);
        cmp <= 9'h000;
        rd_reg(`PSS_STAT_ADDR);
        chk(rd & 32'h1, 32'h1);
        conf = $urandom;
        wr(`PSS_CONF_ADDR, conf);
        chk({30'h0, rs}, {30'h0, `PSS_RESP_OKAY});
        wr(4'h6, ~conf);
        chk({30'h0, rs}, {30'h0, `PSS_RESP_SLVERR});
        rd_reg(`PSS_CONF_ADDR);
        chk(rd, conf);
        rd_reg(4'h6);
        chk({30'h0, rs}, {30'h0, `PSS_RESP_SLVERR});
        // corner levels first, then random supply, enable and sleep levels
        for (int i = 0; i < 24; i++) begin
            {c, slp, v} = (i < 4) ? corner[i] : 11'($urandom) & 11'h63F;
            wr(`PSS_CTRL_ADDR, {31'h0, slp});
            @(posedge aclk);
            cmp <= v;
            ce <= c;
            repeat (3) @(posedge aclk);
            rd_reg(`PSS_ENAB_ADDR);
            chk(rd, {24'h0, exp_en(c, slp, v)});
            @(negedge aclk);
            chk({24'h0, en}, {24'h0, exp_en(c, slp, v)});
        end
        // quiet levels, let frames raised above drain, then one event per message
        @(posedge aclk);
        cmp <= 9'h000;
        ce <= 1'b1;
        wr(`PSS_CTRL_ADDR, 32'h0);
        repeat (400) @(posedge aclk);
        wr(`PSS_STAT_ADDR, 32'h1);
        for (int i = 0; i < 3; i++) begin
            c0 = rx_count;
            @(posedge aclk);
            cmp[ev[i]] <= 1'b1;
            wait_rx(c0);
            chk({24'h0, rx_byte}, {24'h0, `PSS_MSG_HEADER, 4'(2 << i)});
            @(posedge aclk);
            cmp[ev[i]] <= 1'b0;
        end
        chk({31'h0, ferr}, 32'h0);
        // overtemperature trip, toggle while still hot, then cool and toggle
        @(posedge aclk);
        cmp <= 9'h0C0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, en}, 32'h0);
        rd_reg(`PSS_STAT_ADDR);
        chk(rd & 32'h2, 32'h2);
        // cooled but chip enable not yet toggled: still shut down
        @(posedge aclk);
        cmp <= 9'h000;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, en}, 32'h0);
        @(posedge aclk);
        cmp <= 9'h080;
        ce <= 1'b0;
        @(posedge aclk);
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, en}, 32'h0);
        @(posedge aclk);
        cmp <= 9'h000;
        ce <= 1'b0;
        @(posedge aclk);
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, en}, {24'h0, exp_en(1'b1, 1'b0, 9'h000)});
        results();
    end
endmodule
